// ==== tb/isc_coordinator_bench.sv ====
`timescale 1ns/100ps
module isc_coordinator_bench;
  localparam int NC = 2;
  logic        sys_clk, reset_n, mem_brk, slow, hold_req, rd_d;
  logic        plat_grant_c3, plat_grant_c6, plat_hold_hi;
  logic        thr_req_vld [2*NC], thr_req_c1e [2*NC], thr_req_monitor_wait_instruction [2*NC];
  logic [1:0]  thr_req_cst [2*NC];
  logic        thr_irq [2*NC], thr_mon_hit [2*NC], thr_awake [2*NC];
  logic        core_brk_msk [NC], core_flush_done [NC], core_save_done [NC];
  logic        core_rest_done [NC], core_snoop_en [NC], core_flush [NC];
  logic        core_clk_stop [NC], core_save [NC], core_pwr_off [NC];
  logic        core_restore [NC];
  logic [1:0]  core_cst [NC];
  logic [1:0]  pkg_req, pkg_cst, allow_lvl;
  logic        pkg_c1e, pkg_freq_low, pkg_volt_low, l3_snoop_en;
  logic        reg_wr, reg_rd;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [31:0] exp_q [$];
  int          errors, tests_run;

  isc_coordinator #(.NCORE(NC)) u_dut (
    .sys_clk(sys_clk), .reset_n(reset_n), .thr_req_vld(thr_req_vld),
    .thr_req_cst(thr_req_cst), .thr_req_c1e(thr_req_c1e),
    .thr_req_monitor_wait_instruction(thr_req_monitor_wait_instruction), .thr_irq(thr_irq),
    .thr_mon_hit(thr_mon_hit), .core_brk_msk(core_brk_msk),
    .core_flush_done(core_flush_done), .core_save_done(core_save_done),
    .core_rest_done(core_rest_done), .mem_brk(mem_brk),
    .plat_grant_c3(plat_grant_c3), .plat_grant_c6(plat_grant_c6),
    .plat_hold_hi(plat_hold_hi), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .thr_awake(thr_awake), .core_cst(core_cst),
    .core_snoop_en(core_snoop_en), .core_flush(core_flush),
    .core_clk_stop(core_clk_stop), .core_save(core_save),
    .core_pwr_off(core_pwr_off), .core_restore(core_restore),
    .pkg_req(pkg_req), .pkg_cst(pkg_cst), .pkg_c1e(pkg_c1e),
    .pkg_freq_low(pkg_freq_low), .pkg_volt_low(pkg_volt_low),
    .l3_snoop_en(l3_snoop_en)
  );
  isc_plat_model u_plat (
    .sys_clk(sys_clk), .reset_n(reset_n), .pkg_req(pkg_req),
    .allow_lvl(allow_lvl), .slow(slow), .hold_req(hold_req),
    .plat_grant_c3(plat_grant_c3), .plat_grant_c6(plat_grant_c6),
    .plat_hold_hi(plat_hold_hi)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Clock, core-side step answers and read checker
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    for (int c = 0; c < NC; c++) begin
      core_flush_done[c] <= core_flush[c] && !core_flush_done[c];
      core_save_done[c]  <= core_save[c] && !core_save_done[c];
      core_rest_done[c]  <= core_restore[c] && !core_rest_done[c];
    end
  end
  // Oldest noted read value against data one cycle after the strobe
  always @(posedge sys_clk) begin
    if (rd_d === 1'b1) chk("reg_rdata", exp_q.pop_front(), reg_rdata);
    rd_d <= reg_rd;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Tasks
  task chk(string nm, logic [31:0] e, logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task end_sim;
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task wr(logic [3:0] a, logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask
  task rd(logic [3:0] a, logic [31:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    @(posedge sys_clk);
  endtask
  task req(int t, logic [1:0] c, logic e, logic mw);
    thr_req_cst[t] <= c;
    thr_req_c1e[t] <= e;
    thr_req_monitor_wait_instruction[t] <= mw;
    thr_req_vld[t] <= 1'b1;
    @(posedge sys_clk);
    thr_req_vld[t] <= 1'b0;
  endtask
  // Kind 0 interrupt, 1 monitor hit, 2 memory break
  task pulse(int k, int t);
    thr_irq[t] <= (k == 0);
    thr_mon_hit[t] <= (k == 1);
    mem_brk <= (k == 2);
    @(posedge sys_clk);
    thr_irq[t] <= 1'b0;
    thr_mon_hit[t] <= 1'b0;
    mem_brk <= 1'b0;
    @(posedge sys_clk);
  endtask
  function logic [1:0] pick(int s);
    if (s < NC) return core_cst[s];
    if (s == 2) return pkg_cst;
    if (s == 3) return {1'b0, pkg_volt_low};
    return {1'b0, core_clk_stop[0]};
  endfunction
  task wsel(string nm, int s, logic [1:0] e);
    int n;
    n = 0;
    while (pick(s) !== e && n < 60) begin
      @(posedge sys_clk);
      n++;
    end
    chk(nm, e, pick(s));
    if (pick(s) !== e) end_sim();
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    for (int t = 0; t < 2*NC; t++) begin
      thr_req_vld[t] = 1'b0;
      thr_req_c1e[t] = 1'b0;
      thr_req_monitor_wait_instruction[t] = 1'b0;
      thr_req_cst[t] = 2'h0;
      thr_irq[t] = 1'b0;
      thr_mon_hit[t] = 1'b0;
    end
    for (int c = 0; c < NC; c++) begin
      core_brk_msk[c] = 1'b0;
      core_flush_done[c] = 1'b0;
      core_save_done[c] = 1'b0;
      core_rest_done[c] = 1'b0;
    end
    {reset_n, mem_brk, hold_req, rd_d, reg_wr, reg_rd} = 6'h0;
    {reg_addr, reg_wdata, allow_lvl} = 38'h0;
    errors = 0;
    tests_run = 0;
    void'($urandom(49763));
    slow = 1'($urandom());
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    @(posedge sys_clk);
    rd(isc_pkg::ISC_REG_CFG, 32'h0);
    rd(isc_pkg::ISC_REG_MISC, 32'h0);
    wr(4'hf, $urandom());
    rd(4'hf, 32'h0);
    wr(isc_pkg::ISC_REG_CFG, 32'h0000000f);
    rd(isc_pkg::ISC_REG_CFG, 32'h0000000f);
    wr(isc_pkg::ISC_REG_CFG, 32'h00000004);
    // One idle thread alone, then a mixed pair resolves to C1
    req(0, isc_pkg::ISC_C1, 1'b1, 1'b0);
    repeat (4) @(posedge sys_clk);
    chk("core0 single", isc_pkg::ISC_C0, core_cst[0]);
    req(1, isc_pkg::ISC_C3, 1'b0, 1'b0);
    wsel("core0 min", 0, isc_pkg::ISC_C1);
    req(2, isc_pkg::ISC_C1, 1'b1, 1'b0);
    req(3, isc_pkg::ISC_C1, 1'b1, 1'b0);
    wsel("pkg c1", 2, isc_pkg::ISC_C1);
    rd(isc_pkg::ISC_REG_STAT, 32'h00000015);
    wsel("volt low", 3, 2'h1);
    chk("freq low", 1'b1, pkg_freq_low);
    // Interrupt in C1 wakes only its thread
    pulse(0, 0);
    wsel("core0 wake", 0, isc_pkg::ISC_C0);
    chk("awake t0", 1'b1, thr_awake[0]);
    chk("awake t1", 1'b0, thr_awake[1]);
    for (int t = 1; t < 2*NC; t++) pulse(0, t);
    wsel("pkg c0", 2, isc_pkg::ISC_C0);
    // C3 flushes and stops clocks; a snoop break does not wake it
    req(0, isc_pkg::ISC_C3, 1'b0, 1'b0);
    req(1, isc_pkg::ISC_C3, 1'b0, 1'b0);
    wsel("core0 c3", 0, isc_pkg::ISC_C3);
    wsel("clk stop", 4, 2'h1);
    pulse(2, 0);
    repeat (6) @(posedge sys_clk);
    chk("c3 snoop", isc_pkg::ISC_C3, core_cst[0]);
    pulse(0, 1);
    wsel("c3 irq", 0, isc_pkg::ISC_C0);
    chk("c3 t0 asleep", 1'b0, thr_awake[0]);
    pulse(0, 0);
    // Monitored address wakes a monitor-wait core
    req(0, isc_pkg::ISC_C1, 1'b0, 1'b1);
    req(1, isc_pkg::ISC_C1, 1'b0, 1'b1);
    wsel("mw c1", 0, isc_pkg::ISC_C1);
    pulse(1, 0);
    wsel("mon wake", 0, isc_pkg::ISC_C0);
    pulse(0, 1);
    // Eight C3 stays cut short build history; C6 then demotes to C3
    wr(isc_pkg::ISC_REG_CFG, 32'h00000005);
    repeat (8) begin
      req(0, isc_pkg::ISC_C3, 1'b0, 1'b0);
      req(1, isc_pkg::ISC_C3, 1'b0, 1'b0);
      pulse(0, 0);
      pulse(0, 1);
      repeat (4) @(posedge sys_clk);
    end
    req(0, isc_pkg::ISC_C6, 1'b0, 1'b0);
    req(1, isc_pkg::ISC_C6, 1'b0, 1'b0);
    wsel("demoted", 0, isc_pkg::ISC_C3);
    pulse(0, 0);
    pulse(0, 1);
    wr(isc_pkg::ISC_REG_CFG, 32'h00000004);
    // All cores C6: platform allows C3 first, then C6
    allow_lvl <= 2'h2;
    for (int t = 0; t < 2*NC; t++) req(t, isc_pkg::ISC_C6, 1'b0, 1'b0);
    wsel("core0 c6", 0, isc_pkg::ISC_C6);
    wsel("pkg capped", 2, isc_pkg::ISC_C3);
    rd(isc_pkg::ISC_REG_STAT, 32'h0000000e);
    allow_lvl <= 2'h3;
    wsel("pkg c6", 2, isc_pkg::ISC_C6);
    chk("pwr off", 1'b1, core_pwr_off[0]);
    pulse(2, 0);
    wsel("brk back", 2, isc_pkg::ISC_C6);
    hold_req <= 1'b1;
    pulse(2, 0);
    repeat (6) @(posedge sys_clk);
    chk("brk hold", 1'b1, pkg_cst !== isc_pkg::ISC_C6);
    pulse(0, 0);
    wsel("c6 wake", 0, isc_pkg::ISC_C0);
    chk("c6 both", 1'b1, thr_awake[1]);
    end_sim();
  end

  // Watchdog against a hung run
  initial begin
    repeat (20000) @(posedge sys_clk);
    chk("watchdog", 1'b0, 1'b1);
    end_sim();
  end
endmodule

// ==== tb/isc_coordinator_props.sv ====
`timescale 1ns/100ps
module isc_coordinator_props #(
  parameter int NCORE = 2
) (
  input wire logic        sys_clk,
  input wire logic        reset_n,
  input wire logic        thr_irq         [2*NCORE],
  input wire logic        thr_mon_hit     [2*NCORE],
  input wire logic        core_flush_done [NCORE],
  input wire logic        thr_awake       [2*NCORE],
  input wire logic [1:0]  core_cst        [NCORE],
  input wire logic        core_snoop_en   [NCORE],
  input wire logic        core_flush      [NCORE],
  input wire logic        core_clk_stop   [NCORE],
  input wire logic        core_save       [NCORE],
  input wire logic        core_pwr_off    [NCORE],
  input wire logic        pkg_freq_low,
  input wire logic        pkg_volt_low,
  input wire logic        l3_snoop_en
);
  logic wake0;

  // Any wake cause aimed at core 0
  assign wake0 = thr_irq[0] | thr_irq[1] | thr_mon_hit[0] | thr_mon_hit[1];

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////////////////////////////////////////
  // Step sequences
  sequence s_flush_end;
    core_flush[0] && core_flush_done[0];
  endsequence
  sequence s_clk_off;
    ##[1:2] core_clk_stop[0];
  endsequence
  sequence s_c6_irq;
    core_cst[0] == isc_pkg::ISC_C6 && thr_irq[0];
  endsequence
  sequence s_both_up;
    ##[1:4] (thr_awake[0] && thr_awake[1]);
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  chk_l3_snoop_on: assert property (l3_snoop_en)
    else $error("shared cache not snoopable");
  chk_c1_snoops: assert property (
    core_cst[0] == isc_pkg::ISC_C1 |-> core_snoop_en[0])
    else $error("core in C1 stopped snooping");
  chk_flush_stop: assert property (s_flush_end |-> s_clk_off)
    else $error("clock stop did not follow flush");
  chk_save_order: assert property (
    $rose(core_pwr_off[0]) |-> $past(core_save[0]) && !core_save[0])
    else $error("power off without a finished save");
  chk_c3_wake_cause: assert property (
    $past(core_cst[0]) == isc_pkg::ISC_C3 && core_cst[0] == isc_pkg::ISC_C0
    |-> $past(wake0, 1) || $past(wake0, 2) || $past(wake0, 3)
        || $past(wake0, 4))
    else $error("C3 core woke without interrupt");
  chk_c6_wake_both: assert property (s_c6_irq |-> s_both_up)
    else $error("C6 interrupt did not wake both threads");
  chk_via_c0: assert property (
    $past(core_cst[0]) != isc_pkg::ISC_C0 && core_cst[0] != isc_pkg::ISC_C0
    |-> core_cst[0] == $past(core_cst[0]))
    else $error("core changed idle state without C0");
  chk_freq_first: assert property (
    $rose(pkg_volt_low) |-> pkg_freq_low && $past(pkg_freq_low))
    else $error("voltage lowered before frequency");
endmodule

bind isc_coordinator isc_coordinator_props #(.NCORE(NCORE)) u_props (
  .sys_clk(sys_clk), .reset_n(reset_n), .thr_irq(thr_irq),
  .thr_mon_hit(thr_mon_hit), .core_flush_done(core_flush_done),
  .thr_awake(thr_awake), .core_cst(core_cst), .core_snoop_en(core_snoop_en),
  .core_flush(core_flush), .core_clk_stop(core_clk_stop),
  .core_save(core_save), .core_pwr_off(core_pwr_off),
  .pkg_freq_low(pkg_freq_low), .pkg_volt_low(pkg_volt_low),
  .l3_snoop_en(l3_snoop_en)
);

// ==== tb/isc_plat_model.sv ====
`timescale 1ns/100ps
module isc_plat_model (
  input  wire logic       sys_clk,
  input  wire logic       reset_n,
  input  wire logic [1:0] pkg_req,
  input  wire logic [1:0] allow_lvl,
  input  wire logic       slow,
  input  wire logic       hold_req,
  output logic            plat_grant_c3,
  output logic            plat_grant_c6,
  output logic            plat_hold_hi
);
  logic [3:0] c3_dly;
  logic [3:0] c6_dly;

  // Grants follow the request after one or four cycles, up to a limit
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      c3_dly <= 4'h0;
      c6_dly <= 4'h0;
    end else begin
      c3_dly <= {c3_dly[2:0], pkg_req >= 2'h2 && allow_lvl >= 2'h2};
      c6_dly <= {c6_dly[2:0], pkg_req == 2'h3 && allow_lvl == 2'h3};
    end
  end

  // Slow mode answers from the end of the delay line
  assign plat_grant_c3 = slow ? c3_dly[3] : c3_dly[0];
  assign plat_grant_c6 = slow ? c6_dly[3] : c6_dly[0];
  assign plat_hold_hi  = hold_req;
endmodule

// ==== verilog/isc_coordinator.sv ====
`timescale 1ns/100ps
module isc_coordinator #(
  parameter int NCORE = 2
) (
  input  wire logic             sys_clk,
  input  wire logic             reset_n,
  // Per-thread requests, thread t of core c at index 2c+t
  input  wire logic             thr_req_vld   [2*NCORE],
  input  wire logic [1:0]       thr_req_cst   [2*NCORE],
  input  wire logic             thr_req_c1e   [2*NCORE],
  input  wire logic             thr_req_monitor_wait_instruction [2*NCORE],
  input  wire logic             thr_irq       [2*NCORE],
  input  wire logic             thr_mon_hit   [2*NCORE],
  input  wire logic             core_brk_msk  [NCORE],
  input  wire logic             core_flush_done [NCORE],
  input  wire logic             core_save_done  [NCORE],
  input  wire logic             core_rest_done  [NCORE],
  input  wire logic             mem_brk,
  input  wire logic             plat_grant_c3,
  input  wire logic             plat_grant_c6,
  input  wire logic             plat_hold_hi,
  input  wire logic [3:0]       reg_addr,
  input  wire logic [31:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic [31:0]           reg_rdata,
  output logic                  thr_awake     [2*NCORE],
  output logic [1:0]            core_cst      [NCORE],
  output logic                  core_snoop_en [NCORE],
  output logic                  core_flush    [NCORE],
  output logic                  core_clk_stop [NCORE],
  output logic                  core_save     [NCORE],
  output logic                  core_pwr_off  [NCORE],
  output logic                  core_restore  [NCORE],
  output logic [1:0]            pkg_req,
  output logic [1:0]            pkg_cst,
  output logic                  pkg_c1e,
  output logic                  pkg_freq_low,
  output logic                  pkg_volt_low,
  output logic                  l3_snoop_en
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [3:0] cfg_reg;
  logic [0:0] misc_reg;
  logic       dem_en;
  assign dem_en = cfg_reg[isc_pkg::ISC_CFG_DEMEN];

  // Config and misc writes; demotion disabled at reset
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg_reg  <= isc_pkg::ISC_CFG_RST;
      misc_reg <= isc_pkg::ISC_MISC_RST;
    end else if (reg_wr && reg_addr == isc_pkg::ISC_REG_CFG) begin
      cfg_reg <= reg_wdata[3:0];
    end else if (reg_wr && reg_addr == isc_pkg::ISC_REG_MISC) begin
      misc_reg <= reg_wdata[0:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Thread state
  logic [1:0] thr_cst [2*NCORE];
  logic       thr_c1e [2*NCORE];
  logic       thr_mw  [2*NCORE];
  logic [1:0] core_res [NCORE];
  logic       core_res_c1e [NCORE];
  logic [1:0] core_cur [NCORE];
  logic [1:0] core_eff [NCORE];
  logic [3:0] hist [NCORE];

  genvar g;
  generate
    for (g = 0; g < 2*NCORE; g++) begin : g_thr
      localparam int C = g / 2;
      logic wake;
      // Wake: interrupt, or monitor hit when entered by monitor wait
      assign wake = thr_irq[g] || (thr_mon_hit[g] && thr_mw[g]);
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          thr_cst[g] <= isc_pkg::ISC_C0;
          thr_c1e[g] <= 1'b0;
          thr_mw[g]  <= 1'b0;
        end else if (wake ||
            (core_cur[C] == isc_pkg::ISC_C6 &&
             (thr_irq[2*C] || thr_irq[2*C+1]))) begin
          thr_cst[g] <= isc_pkg::ISC_C0;
          thr_c1e[g] <= 1'b0;
          thr_mw[g]  <= 1'b0;
        end else if (thr_req_vld[g] &&
                     thr_cst[g] == isc_pkg::ISC_C0) begin
          // Only from C0 into another idle state
          thr_cst[g] <= thr_req_cst[g];
          thr_c1e[g] <= thr_req_c1e[g];
          thr_mw[g]  <= thr_req_monitor_wait_instruction[g];
        end
      end
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          thr_awake[g] <= 1'b1;
        end else begin
          thr_awake[g] <= (thr_cst[g] == isc_pkg::ISC_C0);
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Core resolution, demotion and sequencing
  generate
    for (g = 0; g < NCORE; g++) begin : g_core
      isc_pkg::isc_seq_e seq_reg;
      isc_pkg::isc_seq_e seq_next;
      logic [1:0] a;
      logic [1:0] b;
      logic [1:0] dem;
      assign a = thr_cst[2*g];
      assign b = thr_cst[2*g+1];
      // Minimum of both threads; C1E only if each thread in C1 asks it
      assign core_res[g] = (a < b) ? a : b;
      assign core_res_c1e[g] =
        (a != isc_pkg::ISC_C1 || thr_c1e[2*g]) &&
        (b != isc_pkg::ISC_C1 || thr_c1e[2*g+1]) &&
        core_res[g] == isc_pkg::ISC_C1;

      // Demotion by residency history; policy bit chooses target
      always_comb begin
        dem = core_res[g];
        if (dem_en && hist[g] >= isc_pkg::ISC_HIST_THR) begin
          if (cfg_reg[isc_pkg::ISC_CFG_POL]) begin
            if (dem > isc_pkg::ISC_C1) dem = isc_pkg::ISC_C1;
          end else if (dem == isc_pkg::ISC_C6) begin
            dem = isc_pkg::ISC_C3;
          end
        end
      end

      // Exit before entry finished is a short stay, later exits are long
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          hist[g] <= 4'h0;
        end else if (core_cur[g] > isc_pkg::ISC_C1 &&
                     core_res[g] == isc_pkg::ISC_C0) begin
          if (seq_reg != isc_pkg::ISC_SQ_CLKOF &&
              seq_reg != isc_pkg::ISC_SQ_PWROF) begin
            if (hist[g] != isc_pkg::ISC_HIST_MAX) hist[g] <= hist[g] + 4'h1;
          end else if (hist[g] != 4'h0) begin
            hist[g] <= hist[g] - 4'h1;
          end
        end
      end

      // Effective core state moves only through C0
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          core_cur[g] <= isc_pkg::ISC_C0;
        end else if (core_res[g] == isc_pkg::ISC_C0) begin
          core_cur[g] <= isc_pkg::ISC_C0;
        end else if (core_cur[g] == isc_pkg::ISC_C0 &&
                     seq_reg == isc_pkg::ISC_SQ_RUN) begin
          core_cur[g] <= dem;
        end
      end
      assign core_eff[g] = core_cur[g];

      // Entry and exit sequencing per core
      always_comb begin
        seq_next = seq_reg;
        case (seq_reg)
          isc_pkg::ISC_SQ_RUN:
            if (core_cur[g] == isc_pkg::ISC_C1) seq_next = isc_pkg::ISC_SQ_HALT;
            else if (core_cur[g] == isc_pkg::ISC_C3)
              seq_next = isc_pkg::ISC_SQ_FLUSH;
            else if (core_cur[g] == isc_pkg::ISC_C6)
              seq_next = isc_pkg::ISC_SQ_SAVE;
          isc_pkg::ISC_SQ_HALT:
            if (core_cur[g] == isc_pkg::ISC_C0) seq_next = isc_pkg::ISC_SQ_RUN;
          isc_pkg::ISC_SQ_FLUSH:
            if (core_flush_done[g]) seq_next = isc_pkg::ISC_SQ_CLKOF;
          isc_pkg::ISC_SQ_CLKOF:
            // Snoops are not wake sources here
            if (core_cur[g] == isc_pkg::ISC_C0)
              seq_next = isc_pkg::ISC_SQ_RUN;
          isc_pkg::ISC_SQ_SAVE:
            if (core_save_done[g]) seq_next = isc_pkg::ISC_SQ_PWROF;
          isc_pkg::ISC_SQ_PWROF:
            if (core_cur[g] == isc_pkg::ISC_C0)
              seq_next = isc_pkg::ISC_SQ_REST;
          isc_pkg::ISC_SQ_REST:
            if (core_rest_done[g]) seq_next = isc_pkg::ISC_SQ_RUN;
          default: seq_next = isc_pkg::ISC_SQ_RUN;
        endcase
      end

      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          seq_reg <= isc_pkg::ISC_SQ_RUN;
        end else begin
          seq_reg <= seq_next;
        end
      end

      // Registered core controls
      always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
          core_cst[g]      <= isc_pkg::ISC_C0;
          core_snoop_en[g] <= 1'b1;
          core_flush[g]    <= 1'b0;
          core_clk_stop[g] <= 1'b0;
          core_save[g]     <= 1'b0;
          core_pwr_off[g]  <= 1'b0;
          core_restore[g]  <= 1'b0;
        end else begin
          core_cst[g]      <= core_cur[g];
          core_snoop_en[g] <= (seq_next == isc_pkg::ISC_SQ_RUN) ||
                              (seq_next == isc_pkg::ISC_SQ_HALT);
          core_flush[g]    <= (seq_next == isc_pkg::ISC_SQ_FLUSH);
          core_clk_stop[g] <= (seq_next == isc_pkg::ISC_SQ_CLKOF);
          core_save[g]     <= (seq_next == isc_pkg::ISC_SQ_SAVE);
          core_pwr_off[g]  <= (seq_next == isc_pkg::ISC_SQ_PWROF);
          core_restore[g]  <= (seq_next == isc_pkg::ISC_SQ_REST);
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Package resolution
  logic [1:0] min_cst;
  logic       all_c1e;
  logic       all_c1_plain;
  logic [1:0] pkg_tgt;
  logic       tgt_c1e;
  logic [1:0] pkg_prev;
  logic       brk_hold;
  logic       any_irq;
  logic       brk_unmasked;
  logic [2:0] fcnt;

  // Lowest core state across cores
  always_comb begin
    min_cst = isc_pkg::ISC_C6;
    all_c1e = 1'b1;
    all_c1_plain = 1'b1;
    for (int i = 0; i < NCORE; i++) begin
      if (core_eff[i] < min_cst) min_cst = core_eff[i];
      if (!core_res_c1e[i]) all_c1e = 1'b0;
      if (core_eff[i] != isc_pkg::ISC_C1) all_c1_plain = 1'b0;
    end
  end

  // Break classification: interrupts versus memory or snoop
  always_comb begin
    any_irq = 1'b0;
    brk_unmasked = 1'b0;
    for (int i = 0; i < 2*NCORE; i++) begin
      if (thr_irq[i]) begin
        any_irq = 1'b1;
        if (!core_brk_msk[i/2]) brk_unmasked = 1'b1;
      end
    end
  end

  // Apply cap, grants and C1E promotion to the request
  always_comb begin
    pkg_tgt = min_cst;
    tgt_c1e = 1'b0;
    if (cfg_reg[isc_pkg::ISC_CFG_CAP] && pkg_tgt > isc_pkg::ISC_C1) begin
      pkg_tgt = isc_pkg::ISC_C1;
      tgt_c1e = 1'b1;
    end
    if (pkg_tgt == isc_pkg::ISC_C6 && !plat_grant_c6) begin
      pkg_tgt = isc_pkg::ISC_C3;
    end
    if (pkg_tgt == isc_pkg::ISC_C3 && !plat_grant_c3) begin
      pkg_tgt = isc_pkg::ISC_C1;
    end
    if (pkg_tgt == isc_pkg::ISC_C1 && min_cst == isc_pkg::ISC_C1) begin
      tgt_c1e = all_c1e ||
        (all_c1_plain && misc_reg[isc_pkg::ISC_MISC_PROMO]);
    end
    if (!cfg_reg[isc_pkg::ISC_CFG_C1E]) tgt_c1e = 1'b0;
  end

  // Package state: direct moves, break handling
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pkg_cst  <= isc_pkg::ISC_C0;
      pkg_c1e  <= 1'b0;
      pkg_prev <= isc_pkg::ISC_C0;
      brk_hold <= 1'b0;
    end else if (any_irq && brk_unmasked) begin
      pkg_cst <= isc_pkg::ISC_C0;
      pkg_c1e <= 1'b0;
    end else if (any_irq || (mem_brk && !plat_hold_hi)) begin
      // Masked or memory break: keep the previous package state
      pkg_cst <= pkg_prev;
    end else if (mem_brk && plat_hold_hi) begin
      pkg_cst  <= isc_pkg::ISC_C0;
      pkg_c1e  <= 1'b0;
      brk_hold <= 1'b1;
    end else if (brk_hold && plat_hold_hi) begin
      pkg_cst <= isc_pkg::ISC_C0;
    end else begin
      brk_hold <= 1'b0;
      pkg_cst  <= pkg_tgt;
      pkg_c1e  <= tgt_c1e;
      pkg_prev <= pkg_tgt;
    end
  end

  // C1E: frequency drop first, voltage after the step delay
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pkg_freq_low <= 1'b0;
      pkg_volt_low <= 1'b0;
      fcnt         <= 3'h0;
    end else if (pkg_c1e && pkg_cst == isc_pkg::ISC_C1) begin
      pkg_freq_low <= 1'b1;
      if (fcnt != 3'(isc_pkg::ISC_FSTEP_CYC)) fcnt <= fcnt + 3'h1;
      else pkg_volt_low <= 1'b1;
    end else begin
      pkg_freq_low <= 1'b0;
      pkg_volt_low <= 1'b0;
      fcnt         <= 3'h0;
    end
  end

  // Request out; L3 stays snoopable in every state; the request carries C1 as well
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pkg_req     <= isc_pkg::ISC_C0;
      l3_snoop_en <= 1'b1;
    end else begin
      pkg_req     <= min_cst;
      l3_snoop_en <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register read, data in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd) begin
      case (reg_addr)
        isc_pkg::ISC_REG_CFG:  reg_rdata <= {28'h0, cfg_reg};
        isc_pkg::ISC_REG_MISC: reg_rdata <= {31'h0, misc_reg};
        isc_pkg::ISC_REG_STAT: reg_rdata <= {27'h0, pkg_c1e, pkg_req, pkg_cst};
        isc_pkg::ISC_REG_CORE: reg_rdata <= {30'h0, core_cur[0]};
        default:               reg_rdata <= 32'h0;
      endcase
    end else begin
      reg_rdata <= 32'h0;
    end
  end

endmodule

// ==== verilog/isc_pkg.sv ====
package isc_pkg;
  // Ordered idle-state code: numeric minimum resolves every level
  typedef enum logic [1:0] {
    ISC_C0 = 2'b00,
    ISC_C1 = 2'b01,
    ISC_C3 = 2'b10,
    ISC_C6 = 2'b11
  } isc_cst_e;

  // Per-core sequencing states
  typedef enum logic [2:0] {
    ISC_SQ_RUN   = 3'b000,
    ISC_SQ_HALT  = 3'b001,
    ISC_SQ_FLUSH = 3'b010,
    ISC_SQ_CLKOF = 3'b011,
    ISC_SQ_SAVE  = 3'b100,
    ISC_SQ_PWROF = 3'b101,
    ISC_SQ_REST  = 3'b110
  } isc_seq_e;

  // Register indices on the plain register port
  localparam logic [3:0] ISC_REG_CFG  = 4'h0;
  localparam logic [3:0] ISC_REG_MISC = 4'h1;
  localparam logic [3:0] ISC_REG_STAT = 4'h2;
  localparam logic [3:0] ISC_REG_CORE = 4'h3;

  // Config and misc register fields
  localparam int ISC_CFG_DEMEN  = 0;
  localparam int ISC_CFG_POL    = 1;
  localparam int ISC_CFG_C1E    = 2;
  localparam int ISC_CFG_CAP    = 3;
  localparam int ISC_MISC_PROMO = 0;
  localparam logic [3:0] ISC_CFG_RST  = 4'h0;
  localparam logic [0:0] ISC_MISC_RST = 1'h0;

  // Residency history: short-stay counter limits
  localparam logic [3:0] ISC_HIST_MAX = 4'hf;
  localparam logic [3:0] ISC_HIST_THR = 4'h8;

  // Frequency step before voltage step, in cycles
  localparam int ISC_FSTEP_NS  = 100;
  localparam int ISC_CLK_NS    = 20;
  localparam int ISC_FSTEP_CYC = (ISC_FSTEP_NS + ISC_CLK_NS - 1) / ISC_CLK_NS;
endpackage
